// *** pkg/node_err_defines.svh ***
/*
  Offsets, field positions, reset values and timing counts of the bus node reset and ECC error log block.
  Assumes a 32-bit register port with byte offsets.
*/
`ifndef NODE_ERR_DEFINES_SVH
`define NODE_ERR_DEFINES_SVH

// ==========================================================================
// Register offsets
`define OFF_NODE_CONTROL   8'h00
`define OFF_BUS_CONFIG     8'h04
`define OFF_BUS_ERROR      8'h08
`define OFF_SYNDROME_0     8'h10
`define OFF_SYNDROME_3     8'h1C
`define OFF_CMD_LOW        8'h20
`define OFF_CMD_HIGH       8'h24

// ==========================================================================
// Field positions
`define NC_NODE_RESET      0
`define NC_SELFTEST_FAILED 1
`define NC_SELFTEST_DONE   2
`define NC_BAD_SEEN        3
`define CFG_CE_REPORT      0
`define BE_UNCORRECTABLE   0
`define BE_CORRECTABLE     1
`define BE_ERR_SEEN        2
`define CH_CNF             8
`define CH_SHARED          9
`define CH_DIRTY           10
`define CH_CYCLE_LSB       12

// ==========================================================================
// Reset values and timing counts
`define BUS_CONFIG_RESET   1'b0
`define ARB_HOLDOFF_CYCLES 5'h10
`define NODE_RESET_CYCLES  5'h10

`endif

// *** pkg/node_err_pkg.sv ***
/*
  Types of the bus node reset and ECC error log block: monitored bus cycles and self-test states.
  Assumes the bus decoder delivers one command or data cycle per clock.
*/
package node_err_pkg;

  // ========================================================================
  // Command cycle as seen on the bus
  typedef struct packed {
    logic        valid;
    logic        parity_err;
    logic        memory;
    logic [38:0] data;
    logic        confirm_line;
    logic        shared;
    logic        dirty;
  } bus_cmd_type;

  // ========================================================================
  // Memory data cycle with the ECC checker verdict
  typedef struct packed {
    logic            valid;
    logic            correctable;
    logic            uncorrectable;
    logic [3:0][6:0] syndrome;
  } bus_data_type;

  // ========================================================================
  // Self-test progress
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_PASS = 3'b010,
    ST_FAIL = 3'b100
  } selftest_state_type;

endpackage

// *** hw/node_err_log.sv ***
/*
  Bus node reset handling and memory-data ECC error log, on the bus clock.
  Assumes a same-clock bus decoder and ECC checker feed bus_cmd and bus_data,
  and a same-clock self-test engine answers selftest_start.
*/
`include "node_err_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module node_err_log
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  // Bus pins
  input  wire logic                        bus_reset_in_n,
  input  wire logic                        bus_err_in,
  input  wire logic                        bad_line_in,
  output logic                             bus_err_out,
  output logic                             bad_out,
  output logic                             selftest_led,
  // Arbitration
  input  wire logic                        arb_want,
  output logic                             arb_request,
  // Monitored bus cycles
  input  wire node_err_pkg::bus_cmd_type   bus_cmd,
  input  wire node_err_pkg::bus_data_type  bus_data,
  // Self-test engine and strap
  input  wire logic                        io_port_node,
  input  wire logic                        selftest_done,
  input  wire logic                        selftest_pass,
  output logic                             selftest_start,
  output logic                             node_in_reset,
  // Register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic [31:0]                      reg_rdata
);
  import node_err_pkg::*;

  // ========================================================================
  // Declarations
  logic [1:0]          bus_reset_sync_reg;
  logic [1:0]          err_sync_reg;
  logic [1:0]          bad_sync_reg;
  logic                logic_reset;
  logic [4:0]          node_reset_cnt_reg;
  logic [4:0]          holdoff_cnt_reg;
  logic                io_port_reg;
  selftest_state_type  st_state_reg;
  selftest_state_type  st_state_next;
  logic                ce_report_reg;
  logic                ce_flag_reg;
  logic                uce_flag_reg;
  logic                err_seen_reg;
  logic                txn_active_reg;
  logic [1:0]          cycle_idx_reg;
  logic [38:0]         cmd_hold_reg;
  logic [2:0]          status_hold_reg;
  logic [3:0][6:0]     syndrome_reg;
  logic [38:0]         cmd_cap_reg;
  logic [2:0]          status_cap_reg;
  logic [1:0]          cycle_cap_reg;
  logic                uce_event;
  logic                ce_event;
  logic                report_event;
  logic                node_reset_req;
  logic                clear_uce;
  logic                clear_ce;

  // Register offset match shared by read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  // ========================================================================
  // Pin synchronisers, two flops before any logic looks at a pin
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_reset_sync_reg <= 2'h3;
      err_sync_reg       <= 2'h0;
      bad_sync_reg       <= 2'h0;
    end
    else
    begin
      bus_reset_sync_reg <= {bus_reset_sync_reg[0], ~bus_reset_in_n};
      err_sync_reg       <= {err_sync_reg[0], bus_err_in};
      bad_sync_reg       <= {bad_sync_reg[0], bad_line_in};
    end
  end

  // Bus reset and node reset share one internal reset path
  assign logic_reset = bus_reset_sync_reg[1] | (node_reset_cnt_reg != 5'h00);

  // ========================================================================
  // Node reset: bit write starts a timed local reset
  assign node_reset_req = reg_write && hit(reg_addr, `OFF_NODE_CONTROL) && reg_wdata[`NC_NODE_RESET];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      node_reset_cnt_reg <= 5'h00;
    else if (node_reset_req && node_reset_cnt_reg == 5'h00)
      node_reset_cnt_reg <= `NODE_RESET_CYCLES;
    else if (node_reset_cnt_reg != 5'h00)
      node_reset_cnt_reg <= node_reset_cnt_reg - 5'h01;
  end

  // Busy flag lets the requester side know accesses are not served
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      node_in_reset <= 1'b1;
    else
      node_in_reset <= logic_reset;
  end

  // Strap is caught while the internal reset is held, not by the async reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      io_port_reg <= 1'b0;
    else if (logic_reset)
      io_port_reg <= io_port_node;
  end

  // ========================================================================
  // Arbitration hold-off after reset and after a seen error strobe
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      holdoff_cnt_reg <= `ARB_HOLDOFF_CYCLES;
    else if (logic_reset)
      holdoff_cnt_reg <= `ARB_HOLDOFF_CYCLES;
    else if (err_sync_reg[1])
      holdoff_cnt_reg <= `ARB_HOLDOFF_CYCLES;
    else if (holdoff_cnt_reg != 5'h00)
      holdoff_cnt_reg <= holdoff_cnt_reg - 5'h01;
  end

  // Request only leaves once the hold-off has run out
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      arb_request <= 1'b0;
    else
      arb_request <= arb_want && !logic_reset && holdoff_cnt_reg == 5'h00 && !err_sync_reg[1];
  end

  // ========================================================================
  // Self-test sequence, restarted by every reset
  always_comb
  begin
    st_state_next = st_state_reg;
    case (st_state_reg)
      ST_RUN:
        if (selftest_done)
          st_state_next = selftest_pass ? ST_PASS : ST_FAIL;
      ST_PASS: st_state_next = ST_PASS;
      ST_FAIL: st_state_next = ST_FAIL;
      default: st_state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      st_state_reg <= ST_RUN;
    else if (logic_reset)
      st_state_reg <= ST_RUN;
    else
      st_state_reg <= st_state_next;
  end

  // Start pulse on the first cycle out of reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      selftest_start <= 1'b0;
    else
      selftest_start <= node_in_reset && !logic_reset;
  end

  // Incomplete line stays driven on failure too; the I/O port node drives it only in the async reset and until its strap is latched
  // Latched strap used, so a strap that moves outside reset cannot glitch the line
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bad_out      <= 1'b1;
      selftest_led <= 1'b0;
    end
    else
    begin
      bad_out      <= !io_port_reg && (logic_reset || st_state_next != ST_PASS);
      selftest_led <= !(!io_port_reg && (logic_reset || st_state_next != ST_PASS));
    end
  end

  // ========================================================================
  // Transaction tracking: index data cycles, drop parity-failed commands
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txn_active_reg  <= 1'b0;
      cycle_idx_reg   <= 2'h0;
      cmd_hold_reg    <= 39'h0;
      status_hold_reg <= 3'h0;
    end
    else if (logic_reset)
    begin
      txn_active_reg <= 1'b0;
      cycle_idx_reg  <= 2'h0;
    end
    else if (bus_cmd.valid)
    begin
      txn_active_reg  <= bus_cmd.memory && !bus_cmd.parity_err;
      cycle_idx_reg   <= 2'h0;
      cmd_hold_reg    <= bus_cmd.data;
      status_hold_reg <= {bus_cmd.dirty, bus_cmd.shared, bus_cmd.confirm_line};
    end
    else if (bus_data.valid && txn_active_reg)
    begin
      // Errors do not end the transaction; it runs through all four cycles
      cycle_idx_reg  <= cycle_idx_reg + 2'h1;
      txn_active_reg <= cycle_idx_reg != 2'h3;
    end
  end

  // ECC verdicts count only inside a live memory transaction
  assign uce_event    = !logic_reset && bus_data.valid && txn_active_reg && bus_data.uncorrectable;
  assign ce_event     = !logic_reset && bus_data.valid && txn_active_reg && !bus_data.uncorrectable
                        && bus_data.correctable && ce_report_reg;
  assign report_event = uce_event || ce_event;

  // ========================================================================
  // Error strobe: one cycle after a report, or on node reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      bus_err_out <= 1'b0;
    else
      bus_err_out <= report_event || (node_reset_req && node_reset_cnt_reg == 5'h00);
  end

  // ========================================================================
  // Capture registers, locked while either flag is held
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syndrome_reg   <= '0;
      cmd_cap_reg    <= 39'h0;
      status_cap_reg <= 3'h0;
      cycle_cap_reg  <= 2'h0;
    end
    else if (report_event && !ce_flag_reg && !uce_flag_reg)
    begin
      syndrome_reg   <= bus_data.syndrome;
      cmd_cap_reg    <= cmd_hold_reg;
      status_cap_reg <= status_hold_reg;
      cycle_cap_reg  <= cycle_idx_reg;
    end
  end

  // ========================================================================
  // Flags: write one to clear, a new event wins over a clear in the same cycle
  assign clear_uce = reg_write && hit(reg_addr, `OFF_BUS_ERROR) && reg_wdata[`BE_UNCORRECTABLE];
  assign clear_ce  = reg_write && hit(reg_addr, `OFF_BUS_ERROR) && reg_wdata[`BE_CORRECTABLE];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      uce_flag_reg <= 1'b0;
      ce_flag_reg  <= 1'b0;
      err_seen_reg <= 1'b0;
    end
    else if (logic_reset)
    begin
      uce_flag_reg <= 1'b0;
      ce_flag_reg  <= 1'b0;
      err_seen_reg <= 1'b0;
    end
    else
    begin
      uce_flag_reg <= uce_event || (uce_flag_reg && !clear_uce);
      ce_flag_reg  <= ce_event || (ce_flag_reg && !clear_ce);
      err_seen_reg <= err_sync_reg[1] || (err_seen_reg && !(reg_write && hit(reg_addr, `OFF_BUS_ERROR)
                      && reg_wdata[`BE_ERR_SEEN]));
    end
  end

  // Correctable reporting enable
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      ce_report_reg <= `BUS_CONFIG_RESET;
    else if (logic_reset)
      ce_report_reg <= `BUS_CONFIG_RESET;
    else if (reg_write && hit(reg_addr, `OFF_BUS_CONFIG))
      ce_report_reg <= reg_wdata[`CFG_CE_REPORT];
  end

  // ========================================================================
  // Read data, one cycle after the strobe; silent while in reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_read || logic_reset)
      reg_rdata <= 32'h0000_0000;
    else if (hit(reg_addr, `OFF_NODE_CONTROL))
    begin
      reg_rdata                      <= 32'h0000_0000;
      reg_rdata[`NC_SELFTEST_FAILED] <= st_state_reg == ST_FAIL;
      reg_rdata[`NC_SELFTEST_DONE]   <= st_state_reg != ST_RUN;
      reg_rdata[`NC_BAD_SEEN]        <= bad_sync_reg[1];
    end
    else if (hit(reg_addr, `OFF_BUS_CONFIG))
      reg_rdata <= {31'h0, ce_report_reg};
    else if (hit(reg_addr, `OFF_BUS_ERROR))
      reg_rdata <= {29'h0, err_seen_reg, ce_flag_reg, uce_flag_reg};
    else if (reg_addr >= `OFF_SYNDROME_0 && reg_addr <= `OFF_SYNDROME_3 && reg_addr[1:0] == 2'h0)
      reg_rdata <= {25'h0, syndrome_reg[reg_addr[3:2]]};
    else if (hit(reg_addr, `OFF_CMD_LOW))
      reg_rdata <= cmd_cap_reg[31:0];
    else if (hit(reg_addr, `OFF_CMD_HIGH))
    begin
      reg_rdata                                       <= 32'h0000_0000;
      reg_rdata[6:0]                                  <= cmd_cap_reg[38:32];
      reg_rdata[`CH_DIRTY:`CH_CNF]                    <= {status_cap_reg[2], status_cap_reg[1], status_cap_reg[0]};
      reg_rdata[`CH_CYCLE_LSB+1:`CH_CYCLE_LSB]        <= cycle_cap_reg;
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule

`default_nettype wire

// *** testbench/node_err_log_props.sv ***
/*
  Port checker for the node reset and ECC error log block.
  Assumes it sees only the top module ports, one clock domain.
*/
`include "node_err_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module node_err_log_props
(
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       reset_n,
  // Watched ports
  input wire logic                       bus_err_in,
  input wire logic                       bus_err_out,
  input wire logic                       bad_out,
  input wire logic                       selftest_led,
  input wire logic                       arb_request,
  input wire node_err_pkg::bus_cmd_type  bus_cmd,
  input wire node_err_pkg::bus_data_type bus_data,
  input wire logic                       io_port_node,
  input wire logic                       selftest_start,
  input wire logic                       node_in_reset,
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_write
);
  import node_err_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic       xact_ok;
  logic [3:0] hold_cnt;
  logic       node_reset_bit_wr;

  // Node reset request that the block must honour
  assign node_reset_bit_wr = reg_write && reg_addr == `OFF_NODE_CONTROL && reg_wdata[0] && !node_in_reset;

  // Open memory transaction; a parity-failed command closes it
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      xact_ok <= 1'b0;
    else if (node_in_reset)
      xact_ok <= 1'b0;
    else if (bus_cmd.valid)
      xact_ok <= bus_cmd.memory && !bus_cmd.parity_err;

  // Hold-off window after reset, kept short of sixteen so sync lag cannot trip it
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      hold_cnt <= 4'hE;
    else if (node_in_reset)
      hold_cnt <= 4'hE;
    else if (hold_cnt != 4'h0)
      hold_cnt <= hold_cnt - 4'h1;

  // ==========================================================================
  // Properties
  property p_led;
    selftest_led == !bad_out;
  endproperty
  property p_err_one;
    bus_err_out |=> !bus_err_out;
  endproperty
  property p_uce_strobe;
    xact_ok && !node_in_reset && bus_data.valid && bus_data.uncorrectable |=> bus_err_out;
  endproperty
  property p_parity_drop;
    !xact_ok && bus_data.valid && !reg_write |=> !bus_err_out;
  endproperty
  property p_node_reset_bit_strobe;
    node_reset_bit_wr |=> bus_err_out;
  endproperty
  property p_node_reset_bit_hold;
    node_reset_bit_wr |-> ##2 node_in_reset [*8];
  endproperty
  property p_start;
    $fell(node_in_reset) |-> ##[0:1] selftest_start;
  endproperty
  property p_bad_reset;
    node_in_reset && !io_port_node |=> bad_out;
  endproperty
  property p_io_quiet;
    io_port_node && $past(io_port_node) && !node_in_reset |-> !bad_out;
  endproperty
  property p_arb_boot;
    hold_cnt != 4'h0 && !node_in_reset |-> !arb_request;
  endproperty
  property p_arb_err;
    bus_err_in |-> ##5 !arb_request [*8];
  endproperty

  a_led:
    assert property (p_led) else $error("led does not mirror bad drive");
  a_err_one:
    assert property (p_err_one) else $error("error strobe longer than one cycle");
  a_uce_strobe:
    assert property (p_uce_strobe) else $error("no strobe after bad data");
  a_parity_drop:
    assert property (p_parity_drop) else $error("strobe for ignored transaction");
  a_node_reset_bit_strobe:
    assert property (p_node_reset_bit_strobe) else $error("no strobe on node reset");
  a_node_reset_bit_hold:
    assert property (p_node_reset_bit_hold) else $error("node reset too short");
  a_start:
    assert property (p_start) else $error("self-test not started");
  a_bad_reset:
    assert property (p_bad_reset) else $error("bad line not driven in reset");
  a_io_quiet:
    assert property (p_io_quiet) else $error("io port node drives bad line");
  a_arb_boot:
    assert property (p_arb_boot) else $error("request too soon after reset");
  a_arb_err:
    assert property (p_arb_err) else $error("request too soon after error strobe");

  c_uce: cover property (xact_ok && bus_data.valid && bus_data.uncorrectable);
  c_node_reset_bit: cover property (node_reset_bit_wr);
  c_arb: cover property ($rose(arb_request));
endmodule

bind node_err_log node_err_log_props u_props
(
  .clk_sys(clk_sys), .reset_n(reset_n), .bus_err_in(bus_err_in), .bus_err_out(bus_err_out),
  .bad_out(bad_out), .selftest_led(selftest_led), .arb_request(arb_request), .bus_cmd(bus_cmd),
  .bus_data(bus_data), .io_port_node(io_port_node), .selftest_start(selftest_start),
  .node_in_reset(node_in_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write)
);
`default_nettype wire

// *** testbench/bus_peer_model.sv ***
/*
  Other bus nodes: issue memory transactions, error strobes, share the bad line.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_peer_model
(
  // Clock
  input  wire logic                   clk_sys,
  // Bus lines toward the node
  output node_err_pkg::bus_cmd_type   bus_cmd,
  output node_err_pkg::bus_data_type  bus_data,
  output logic                        bus_err_in,
  output logic                        bad_line_in,
  input  wire logic                   bad_out,
  input  wire logic                   peer_bad
);
  import node_err_pkg::*;

  // Wired-OR bad line, skewed off the clock since nodes drive it freely
  assign #7 bad_line_in = bad_out | peer_bad;

  initial
  begin
    bus_cmd = '0;
    bus_data = '0;
    bus_err_in = 1'b0;
  end

  // Memory transaction: command then four data cycles, one bad at idx
  task automatic xact(input logic par, input logic [38:0] d, input logic [2:0] csd,
                      input logic [1:0] idx, input logic [1:0] kind, output logic [27:0] syn);
    bus_data_type dc;
    @(posedge clk_sys);
    bus_cmd <= {1'h1, par, 1'h1, d, csd[0], csd[1], csd[2]};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      bus_cmd <= {1'h0, 44'({$urandom, $urandom})};
      dc = {1'h1, i == idx && kind[1], i == idx && kind[0], 28'($urandom)};
      if (i == idx)
        syn = dc.syndrome;
      bus_data <= dc;
    end
    @(posedge clk_sys);
    bus_data <= {1'h0, 30'($urandom)}; // Released lines do not keep data
  endtask

  // One-cycle error strobe from another node
  task automatic err_pulse;
    @(posedge clk_sys);
    bus_err_in <= 1'h1;
    @(posedge clk_sys);
    bus_err_in <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the node reset and ECC error log block.
  Assumes the peer model and the bound checker sit beside the design.
*/
`include "node_err_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import node_err_pkg::*;
  logic clk_sys = 1'h0, reset_n = 1'h0, bus_reset_in_n = 1'h1, arb_want = 1'h1, io_port_node = 1'h0;
  logic selftest_pass = 1'h1, reg_write = 1'h0, reg_read = 1'h0, peer_bad = 1'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [3:0] st_cnt = 4'h6;
  logic bus_err_in, bad_line_in, bus_err_out, bad_out, selftest_led, arb_request, selftest_start, node_in_reset;
  bus_cmd_type bus_cmd;
  bus_data_type bus_data;
  int fails = 0, num_checks = 0, err_cnt = 0;

  always #20 clk_sys = !clk_sys;

  // Self-test engine finishes six cycles after each start
  always @(posedge clk_sys)
    if (node_in_reset || selftest_start)
      st_cnt <= 4'h6;
    else if (st_cnt != 4'h0)
      st_cnt <= st_cnt - 4'h1;

  // Count strobe cycles driven by the node
  always @(posedge clk_sys)
    if (bus_err_out === 1'h1)
      err_cnt++;

  node_err_log u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus_reset_in_n(bus_reset_in_n),
    .bus_err_in(bus_err_in), .bad_line_in(bad_line_in), .bus_err_out(bus_err_out), .bad_out(bad_out),
    .selftest_led(selftest_led), .arb_want(arb_want), .arb_request(arb_request), .bus_cmd(bus_cmd),
    .bus_data(bus_data), .io_port_node(io_port_node), .selftest_done(st_cnt == 4'h0),
    .selftest_pass(selftest_pass), .selftest_start(selftest_start), .node_in_reset(node_in_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  bus_peer_model u_peer (.clk_sys(clk_sys), .bus_cmd(bus_cmd), .bus_data(bus_data),
    .bus_err_in(bus_err_in), .bad_line_in(bad_line_in), .bad_out(bad_out), .peer_bad(peer_bad));

  // ==========================================================================
  // Helpers
  task automatic wrap_up;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clk_sys);
    reg_write <= 1'h0;
    @(posedge clk_sys);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clk_sys);
    reg_read <= 1'h0;
    #1 chk($sformatf("reg %h", a), exp, reg_rdata & m);
    @(posedge clk_sys);
  endtask

  // Bounded wait for the end of reset plus self-test; no accesses before it
  task automatic wait_ready;
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    while (node_in_reset !== 1'h0 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 100)
    begin
      fails++;
      wrap_up;
    end
    repeat (12) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] cmd_hi(input logic [38:0] d, input logic [2:0] csd, input logic [1:0] idx);
    return {18'h0, idx, 1'h0, csd, 1'h0, d[38:32]};
  endfunction

  task automatic chk_cap(input logic [27:0] syn, input logic [38:0] d, input logic [2:0] csd, input logic [1:0] i);
    for (int k = 0; k < 4; k++)
      chk_rd(8'(`OFF_SYNDROME_0 + 4 * k), 32'h7F, {25'h0, syn[7*k+:7]});
    chk_rd(`OFF_CMD_LOW, 32'hFFFFFFFF, d[31:0]);
    chk_rd(`OFF_CMD_HIGH, 32'h37FF, cmd_hi(d, csd, i));
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [38:0] d, d0;
    logic [2:0] csd;
    logic [1:0] idx, kind;
    logic [27:0] syn, syn0;
    int e0;
    void'($urandom(32'h9d29));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    wait_ready;
    chk_rd(`OFF_BUS_CONFIG, 32'h1, 32'h0);
    chk_rd(`OFF_BUS_ERROR, 32'h7, 32'h0);
    chk_rd(`OFF_NODE_CONTROL, 32'hF, 32'h4);
    chk_rd(8'h3C, 32'hFFFFFFFF, 32'h0);
    chk("led", 1'h1, selftest_led);
    chk("arb", 1'h1, arb_request);
    // Uncorrectable with reporting off, correctable with it off and on, both bits with it on; both bits means uncorrectable
    for (int k = 0; k < 4; k++)
    begin
      kind = (k == 0) ? 2'h1 : (k == 3) ? 2'h3 : 2'h2;
      wr(`OFF_BUS_CONFIG, {31'h0, k >= 2});
      d = 39'({$urandom, $urandom});
      csd = 3'($urandom);
      idx = 2'($urandom);
      e0 = err_cnt;
      u_peer.xact(1'h0, d, csd, idx, kind, syn);
      repeat (4) @(posedge clk_sys);
      chk("strobe", 32'(kind[0] || k >= 2), 32'(err_cnt - e0));
      chk_rd(`OFF_BUS_ERROR, 32'h3, kind[0] ? 32'h1 : (k >= 2) ? 32'h2 : 32'h0);
      if (kind[0] || k >= 2)
        chk_cap(syn, d, csd, idx);
      wr(`OFF_BUS_ERROR, 32'h0);
      chk_rd(`OFF_BUS_ERROR, 32'h3, kind[0] ? 32'h1 : (k >= 2) ? 32'h2 : 32'h0);
      wr(`OFF_BUS_ERROR, 32'h7);
      chk_rd(`OFF_BUS_ERROR, 32'h3, 32'h0);
    end
    // Capture lock: first report held while either flag stands
    d0 = 39'({$urandom, $urandom});
    u_peer.xact(1'h0, d0, csd, 2'h3, 2'h2, syn0);
    u_peer.xact(1'h0, d, 3'h5, 2'h0, 2'h1, syn);
    repeat (4) @(posedge clk_sys);
    chk_rd(`OFF_BUS_ERROR, 32'h3, 32'h3);
    wr(`OFF_BUS_ERROR, 32'h2);
    u_peer.xact(1'h0, d, 3'h2, 2'h1, 2'h1, syn);
    repeat (4) @(posedge clk_sys);
    chk_cap(syn0, d0, csd, 2'h3);
    wr(`OFF_BUS_ERROR, 32'h7);
    // Parity-failed command: its bad data goes unreported
    e0 = err_cnt;
    u_peer.xact(1'h1, d, csd, 2'h2, 2'h1, syn);
    repeat (4) @(posedge clk_sys);
    chk("strobe", 32'h0, 32'(err_cnt - e0));
    chk_rd(`OFF_BUS_ERROR, 32'h3, 32'h0);
    // Node reset with a failing self-test clears flags and config
    u_peer.xact(1'h0, d, csd, 2'h0, 2'h1, syn);
    selftest_pass <= 1'h0;
    e0 = err_cnt;
    wr(`OFF_NODE_CONTROL, 32'h1);
    #1 chk("strobe", 32'h1, 32'(err_cnt - e0));
    wait_ready;
    chk_rd(`OFF_BUS_ERROR, 32'h3, 32'h0);
    chk_rd(`OFF_BUS_CONFIG, 32'h1, 32'h0);
    chk_rd(`OFF_NODE_CONTROL, 32'hF, 32'hE);
    chk("led", 1'h0, selftest_led);
    // Bus reset with a passing self-test, then an error strobe from a peer
    selftest_pass <= 1'h1;
    bus_reset_in_n <= 1'h0;
    repeat (4) @(posedge clk_sys);
    bus_reset_in_n <= 1'h1;
    wait_ready;
    chk("bad", 1'h0, bad_out);
    u_peer.err_pulse;
    repeat (10) @(posedge clk_sys);
    chk("arb", 1'h0, arb_request);
    chk_rd(`OFF_BUS_ERROR, 32'h4, 32'h4);
    repeat (18) @(posedge clk_sys);
    chk("arb", 1'h1, arb_request);
    arb_want <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk("arb", 1'h0, arb_request);
    // Port node leaves the bad line undriven once ready; it still sees other nodes drive it
    reset_n <= 1'h0;
    io_port_node <= 1'h1;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    wait_ready;
    peer_bad <= 1'h1;
    repeat (4) @(posedge clk_sys);
    chk("bad", 1'h0, bad_out);
    chk_rd(`OFF_NODE_CONTROL, 32'hF, 32'hC);
    wrap_up;
  end
endmodule
`default_nettype wire
